// ---- core/sip_link_if.sv ----
// Carrier between the link-clock receiver and the system-clock protocol engine.
// Assumes the receiver is written on the link clock and read on the system clock.
`timescale 1ns/1ps
interface sip_link_if;
	logic [7:0] rxByte;
	modport link (output rxByte);
	modport core (input rxByte);
endinterface

// ---- core/sip_link_rx.sv ----
// Link-side receive shifter, clocked by the controller's serial clock.
// Assumes the system side reads the byte only after seeing the matching clock edge.
`timescale 1ns/1ps
module sip_link_rx (
	// Link pins
	input wire logic sclClk,
	input wire logic sdaIn,
	// Received byte towards the protocol engine
	sip_link_if.link lnk
);
	// Data only; it is never read before eight fresh edges have filled it
	always_ff @(posedge sclClk) begin
		lnk.rxByte <= {lnk.rxByte[6:0], sdaIn};
	end
endmodule

// ---- core/sip_pkg.sv ----
// Constants, states and timing figures shared by the sensor two-wire target port.
// Assumes a 40 MHz system clock; the link clock is the controller's serial clock.
package sip_pkg;
	localparam int CLK_MHZ = 40;
	// Watchdog periods in microseconds, then in system clock cycles
	localparam int WD_SHORT_US = 1000;
	localparam int WD_LONG_US = 50000;
	localparam int WD_SHORT_CYCLES = WD_SHORT_US * CLK_MHZ;
	localparam int WD_LONG_CYCLES = WD_LONG_US * CLK_MHZ;
	// Target addresses for the address select pin low and high
	localparam logic [6:0] TARGET_ADDR_LOW = 7'h18;
	localparam logic [6:0] TARGET_ADDR_HIGH = 7'h19;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [7:0] ADDR_STEP = 8'h01;
	localparam logic RW_READ = 1'b1;
	// Pin positions in the synchroniser vector
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SEL = 2;
	localparam int PIN_COUNT = 3;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_REGA = 9'h004,
		ST_WDATA = 9'h008,
		ST_ACKA = 9'h010,
		ST_ACKR = 9'h020,
		ST_ACKW = 9'h040,
		ST_TX = 9'h080,
		ST_MACK = 9'h100
	} sip_state_t;
endpackage

// ---- core/sip_target.sv ----
// Two-wire target port: protocol engine on the system clock, receiver on the link clock.
// Assumes open-drain pads outside, a register file answering regRdData for regAddr in the
// same cycle, and configuration bits that are static on the system clock.
//
// Behaviour
// R1: Controller opens write with start, address, write bit.
// R2: Register byte acknowledged, then data byte written.
// R3: Controller stops after data byte acknowledge.
// R4: Writes unlimited; address advances unless trapped.
// R5: Read is write phase, repeated start, read.
// R6: Read address bit one; device drives data.
// R7: Controller acknowledges low to continue reading.
// R8: Not-acknowledge ends output; device releases data.
// R9: Read address advances after each byte.
// R10: Each read starts at last written address.
// R11: Read start defaults to register zero.
// R12: Watchdog frees bus held by the device.
// R13: Watchdog enable bit and period select bit.
// R14: Controller idles two microseconds after writes, performance.
// R15: Controller idles 450 microseconds after writes, low power.
// R16: Post-write idle applies to every following access.
// R17: Address 0x18 or 0x19 per select pin.
// R18: Stop right after start is not recognised.
// R19: Foreign addresses get no acknowledge, no drive.
`timescale 1ns/1ps
module sip_target #(
	parameter int WD_SHORT_CYCLES = sip_pkg::WD_SHORT_CYCLES,
	parameter int WD_LONG_CYCLES = sip_pkg::WD_LONG_CYCLES
) (
	// System clock and reset
	input wire logic clk,
	input wire logic srst,
	// Two-wire link
	input wire logic sclClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addressSelectPin,
	// Configuration
	input wire logic busWatchdogEnable,
	input wire logic busWatchdogPeriodSelect,
	// Register file side
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic regTrap,
	// Status
	output logic watchdogFired
);
	localparam int WD_W = $clog2(WD_LONG_CYCLES + 1);

	if (WD_SHORT_CYCLES < 1 || WD_LONG_CYCLES < WD_SHORT_CYCLES) begin : gBadParam
		$error("watchdog periods must be positive and ordered");
	end

	sip_link_if lnk ();

	sip_link_rx uRx (
		.sclClk(sclClk),
		.sdaIn(sdaIn),
		.lnk(lnk.link)
	);

	// Pin synchronisers: a change counts once stages two and three agree
	logic [sip_pkg::PIN_COUNT-1:0] pinRaw;
	logic [sip_pkg::PIN_COUNT-1:0] syncA_r;
	logic [sip_pkg::PIN_COUNT-1:0] syncB_r;
	logic [sip_pkg::PIN_COUNT-1:0] syncC_r;
	logic [sip_pkg::PIN_COUNT-1:0] filt_r;
	logic [sip_pkg::PIN_COUNT-1:0] prev_r;
	assign pinRaw = {addressSelectPin, sdaIn, sclClk};

	for (genvar i = 0; i < sip_pkg::PIN_COUNT; i++) begin : gSync
		always_ff @(posedge clk) begin
			if (srst) begin
				syncA_r[i] <= 1'b1;
				syncB_r[i] <= 1'b1;
				syncC_r[i] <= 1'b1;
				filt_r[i] <= 1'b1;
				prev_r[i] <= 1'b1;
			end else begin
				syncA_r[i] <= pinRaw[i];
				syncB_r[i] <= syncA_r[i];
				syncC_r[i] <= syncB_r[i];
				if (syncB_r[i] == syncC_r[i]) begin
					filt_r[i] <= syncC_r[i];
				end
				prev_r[i] <= filt_r[i];
			end
		end
	end

	// Bus events
	wire sclHigh = filt_r[sip_pkg::PIN_SCL];
	wire sdaLevel = filt_r[sip_pkg::PIN_SDA];
	wire sclRise = sclHigh & ~prev_r[sip_pkg::PIN_SCL];
	wire sclFall = ~sclHigh & prev_r[sip_pkg::PIN_SCL];
	wire sdaRise = sdaLevel & ~prev_r[sip_pkg::PIN_SDA];
	wire sdaFall = ~sdaLevel & prev_r[sip_pkg::PIN_SDA];
	wire startEv = sclHigh & prev_r[sip_pkg::PIN_SCL] & sdaFall;
	wire stopEv = sclHigh & prev_r[sip_pkg::PIN_SCL] & sdaRise;

	sip_pkg::sip_state_t state_r, stateNxt;
	logic [3:0] bitCnt_r, bitCntNxt;
	logic sdaOe_r, sdaOeNxt;
	logic [7:0] regAddr_r, regAddrNxt;
	logic [7:0] ptr_r, ptrNxt;
	logic rw_r, rwNxt;
	logic [7:0] tx_r, txNxt;
	logic wrEn_r, wrEnNxt;
	logic [7:0] wrData_r, wrDataNxt;
	logic arm_r, armNxt;
	logic [WD_W-1:0] wdCnt_r, wdCntNxt;
	logic wdFired_r;
	logic sdaOut_r;

	// Own address from the strap pin; the received byte is stable since its eighth edge
	wire [6:0] ownAddr = filt_r[sip_pkg::PIN_SEL] ? sip_pkg::TARGET_ADDR_HIGH
		: sip_pkg::TARGET_ADDR_LOW;
	wire targetAcknowledge = (lnk.rxByte[7:1] == ownAddr); // [R17] [R19]
	wire controllerNotAcknowledge = sdaLevel;
	wire byteEnd = sclFall && (bitCnt_r == sip_pkg::BYTE_BITS);
	wire rxPhase = (state_r == sip_pkg::ST_ADDR) || (state_r == sip_pkg::ST_REGA)
		|| (state_r == sip_pkg::ST_WDATA) || (state_r == sip_pkg::ST_TX);
	wire [WD_W-1:0] wdLimit = busWatchdogPeriodSelect ? WD_W'(WD_LONG_CYCLES)
		: WD_W'(WD_SHORT_CYCLES);
	// Watchdog counts only while this port pulls the data line and the clock stands still
	wire wdTrip = busWatchdogEnable && sdaOe_r && (wdCnt_r == wdLimit); // [R12] [R13]

	always_comb begin
		stateNxt = state_r;
		bitCntNxt = bitCnt_r;
		sdaOeNxt = sdaOe_r;
		regAddrNxt = regAddr_r;
		ptrNxt = ptr_r;
		rwNxt = rw_r;
		txNxt = tx_r;
		wrEnNxt = 1'b0;
		wrDataNxt = wrData_r;
		armNxt = arm_r | sclFall;
		if (startEv) begin
			stateNxt = sip_pkg::ST_ADDR;
			bitCntNxt = sip_pkg::BIT_ZERO;
			sdaOeNxt = 1'b0;
			armNxt = 1'b0;
		end else if (stopEv && arm_r) begin
			// A stop with no clock low since the start is ignored [R18]
			stateNxt = sip_pkg::ST_IDLE;
			sdaOeNxt = 1'b0;
		end else begin
			if (sclRise && rxPhase && bitCnt_r != sip_pkg::BYTE_BITS) begin
				bitCntNxt = bitCnt_r + 4'h1;
			end
			unique case (state_r)
				sip_pkg::ST_IDLE: begin
				end
				sip_pkg::ST_ADDR: begin
					if (byteEnd && targetAcknowledge) begin
						stateNxt = sip_pkg::ST_ACKA;
						sdaOeNxt = 1'b1; // [R17]
						rwNxt = lnk.rxByte[0];
						if (lnk.rxByte[0] == sip_pkg::RW_READ) begin
							regAddrNxt = ptr_r; // [R10]
						end
					end else if (byteEnd) begin
						stateNxt = sip_pkg::ST_IDLE; // [R19]
					end
				end
				sip_pkg::ST_REGA: begin
					if (byteEnd) begin
						stateNxt = sip_pkg::ST_ACKR;
						sdaOeNxt = 1'b1; // [R2]
						regAddrNxt = lnk.rxByte;
						ptrNxt = lnk.rxByte; // [R10]
					end
				end
				sip_pkg::ST_WDATA: begin
					if (byteEnd) begin
						stateNxt = sip_pkg::ST_ACKW;
						sdaOeNxt = 1'b1;
						wrEnNxt = 1'b1; // [R2]
						wrDataNxt = lnk.rxByte;
					end
				end
				sip_pkg::ST_ACKA: begin
					if (sclFall) begin
						bitCntNxt = sip_pkg::BIT_ZERO;
						if (rw_r == sip_pkg::RW_READ) begin
							stateNxt = sip_pkg::ST_TX;
							txNxt = regRdData;
							sdaOeNxt = ~regRdData[7]; // [R6]
						end else begin
							stateNxt = sip_pkg::ST_REGA;
							sdaOeNxt = 1'b0;
						end
					end
				end
				sip_pkg::ST_ACKR: begin
					if (sclFall) begin
						stateNxt = sip_pkg::ST_WDATA;
						bitCntNxt = sip_pkg::BIT_ZERO;
						sdaOeNxt = 1'b0;
					end
				end
				sip_pkg::ST_ACKW: begin
					if (sclFall) begin
						stateNxt = sip_pkg::ST_WDATA;
						bitCntNxt = sip_pkg::BIT_ZERO;
						sdaOeNxt = 1'b0;
						if (!regTrap) begin
							regAddrNxt = regAddr_r + sip_pkg::ADDR_STEP; // [R4]
						end
					end
				end
				sip_pkg::ST_TX: begin
					if (byteEnd) begin
						stateNxt = sip_pkg::ST_MACK;
						sdaOeNxt = 1'b0;
					end else if (sclFall && bitCnt_r != sip_pkg::BIT_ZERO) begin
						txNxt = {tx_r[6:0], 1'b0};
						sdaOeNxt = ~tx_r[6]; // [R6]
					end
				end
				sip_pkg::ST_MACK: begin
					if (sclRise && controllerNotAcknowledge) begin
						stateNxt = sip_pkg::ST_IDLE; // [R8]
					end else if (sclRise) begin
						regAddrNxt = regAddr_r + sip_pkg::ADDR_STEP; // [R9]
					end else if (sclFall) begin
						stateNxt = sip_pkg::ST_TX;
						bitCntNxt = sip_pkg::BIT_ZERO;
						txNxt = regRdData;
						sdaOeNxt = ~regRdData[7];
					end
				end
			endcase
		end
		if (wdTrip) begin
			stateNxt = sip_pkg::ST_IDLE; // [R12]
			bitCntNxt = sip_pkg::BIT_ZERO;
			sdaOeNxt = 1'b0;
		end
	end

	assign wdCntNxt = (!busWatchdogEnable || !sdaOe_r || sclRise || sclFall || wdTrip)
		? '0 : wdCnt_r + WD_W'(1); // [R13]

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= sip_pkg::ST_IDLE;
			bitCnt_r <= sip_pkg::BIT_ZERO;
			sdaOe_r <= 1'b0;
			regAddr_r <= sip_pkg::PTR_RESET;
			ptr_r <= sip_pkg::PTR_RESET; // [R11]
			rw_r <= 1'b0;
			tx_r <= '0;
			wrEn_r <= 1'b0;
			wrData_r <= '0;
			arm_r <= 1'b0;
			wdCnt_r <= '0;
			wdFired_r <= 1'b0;
			sdaOut_r <= 1'b0;
		end else begin
			state_r <= stateNxt;
			bitCnt_r <= bitCntNxt;
			sdaOe_r <= sdaOeNxt;
			regAddr_r <= regAddrNxt;
			ptr_r <= ptrNxt;
			rw_r <= rwNxt;
			tx_r <= txNxt;
			wrEn_r <= wrEnNxt;
			wrData_r <= wrDataNxt;
			arm_r <= armNxt;
			wdCnt_r <= wdCntNxt;
			wdFired_r <= wdTrip;
			sdaOut_r <= 1'b0;
		end
	end

	// Open drain: the line is only ever pulled low
	assign sdaOut = sdaOut_r;
	assign sdaOe = sdaOe_r;
	assign regAddr = regAddr_r;
	assign regWrEn = wrEn_r;
	assign regWrData = wrData_r;
	assign watchdogFired = wdFired_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence sAddrEnd;
		state_r == sip_pkg::ST_ADDR && byteEnd && !startEv && !wdTrip;
	endsequence
	sequence sReadAccept;
		sAddrEnd ##0 targetAcknowledge && lnk.rxByte[0] == sip_pkg::RW_READ;
	endsequence
	sequence sAckEndRead;
		state_r == sip_pkg::ST_ACKA && rw_r && sclFall && !startEv && !stopEv && !wdTrip;
	endsequence

	a_addr_ack_drive: assert property (sAddrEnd ##0 targetAcknowledge |=> sdaOe_r ##0 state_r == sip_pkg::ST_ACKA) else $error("own address not acknowledged"); // [R17]
	a_foreign_addr_ignored: assert property (sAddrEnd ##0 !targetAcknowledge |=> !sdaOe_r && state_r == sip_pkg::ST_IDLE) else $error("foreign address answered"); // [R19]
	a_write_data_strobe: assert property (state_r == sip_pkg::ST_WDATA && byteEnd && !startEv && !wdTrip |=> regWrEn && regWrData == $past(lnk.rxByte)) else $error("data byte not written"); // [R2]
	a_write_addr_step: assert property (state_r == sip_pkg::ST_ACKW && sclFall && !startEv && !stopEv && !wdTrip |=> regAddr == $past(regAddr) + ($past(regTrap) ? 8'h00 : 8'h01)) else $error("write address step wrong"); // [R4]
	a_read_start_ptr: assert property (sReadAccept |=> regAddr == $past(ptr_r) ##0 regAddr == ptr_r) else $error("read did not start at pointer"); // [R10]
	a_read_first_bit: assert property (sReadAccept ##[1:300] sAckEndRead |=> state_r == sip_pkg::ST_TX && sdaOe_r == ~tx_r[7]) else $error("first read bit not driven"); // [R6]
	a_read_addr_step: assert property (state_r == sip_pkg::ST_MACK && sclRise && !sdaLevel && !startEv && !stopEv && !wdTrip |=> regAddr == $past(regAddr) + 8'h01) else $error("read address not advanced"); // [R9]
	a_nack_release: assert property (state_r == sip_pkg::ST_MACK && sclRise && sdaLevel && !startEv |=> !sdaOe_r [*2] ##0 state_r == sip_pkg::ST_IDLE) else $error("bus not released after not-acknowledge"); // [R8]
	a_ptr_reset_zero: assert property ($fell(srst) |-> ptr_r == sip_pkg::PTR_RESET && regAddr == sip_pkg::PTR_RESET) else $error("read pointer not zero after reset"); // [R11]
	a_watchdog_frees: assert property (wdTrip |=> !sdaOe_r && watchdogFired && state_r == sip_pkg::ST_IDLE) else $error("watchdog did not free the bus"); // [R12]
	a_watchdog_off: assert property (!busWatchdogEnable |=> wdCnt_r == '0 && !watchdogFired) else $error("watchdog ran while disabled"); // [R13]
	a_stop_unarmed: assert property (stopEv && !arm_r && !startEv && !wdTrip |=> state_r == $past(state_r)) else $error("stop after bare start recognised"); // [R18]
endmodule

// ---- verification/sip_ctrl_model.sv ----
// Two-wire bus controller model: drives the serial clock and pulls the data line.
// Assumes the bench resolves the data line with a pull-up from every pull enable.
`timescale 1ns/1ps
module sip_ctrl_model (
	// Bus
	output logic scl,
	output logic sdaPull,
	input wire logic sda
);
	// Quarter bit, off the system clock grid; keeps each level above six system clocks
	localparam realtime Q = 163;
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	// Serves as start and repeated start alike
	task automatic start();
		#Q sdaPull = 1'b0;
		#Q scl = 1'b1;
		#Q sdaPull = 1'b1;
		#Q scl = 1'b0;
	endtask
	task automatic stop();
		#Q sdaPull = 1'b1;
		#Q scl = 1'b1;
		#Q sdaPull = 1'b0;
		#Q;
	endtask
	// Start then stop with the clock held high; leaves the clock low afterwards
	task automatic bareStartStop();
		#Q sdaPull = 1'b1;
		#Q sdaPull = 1'b0;
		#Q scl = 1'b0;
	endtask
	task automatic clockBit(input logic b, output logic r);
		#Q sdaPull = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask
	task automatic putByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clockBit(d[i], r);
		clockBit(1'b1, ack);
	endtask
	// Low acknowledge asks for more, high ends the read
	task automatic getByte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
		clockBit(last, r);
	endtask
endmodule

// ---- verification/sip_target_tb.sv ----
// Self-checking bench for the two-wire target port with a small register file.
// Assumes the controller model and an open-drain data line with pull-up.
`timescale 1ns/1ps
module sip_target_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic addressSelectPin = 1'b0;
	logic busWatchdogEnable = 1'b0;
	logic busWatchdogPeriodSelect = 1'b0;
	logic [7:0] regAddr, regWrData, regRdData, rd;
	logic regWrEn, sdaOut, sdaOe, watchdogFired, scl, sdaPull, ack, regTrap;
	logic [6:0] dev = sip_pkg::TARGET_ADDR_LOW;
	logic [7:0] regs [256];
	wire sda;
	int n_fail = 0;
	int checked = 0;
	assign sda = !(sdaPull | sdaOe);
	assign regRdData = regs[regAddr];
	assign regTrap = regAddr == 8'hF0;
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (regWrEn) regs[regAddr] <= regWrData;
	sip_target #(.WD_SHORT_CYCLES(50), .WD_LONG_CYCLES(200)) uut (.clk(clk), .srst(srst),
		.sclClk(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addressSelectPin(addressSelectPin), .busWatchdogEnable(busWatchdogEnable),
		.busWatchdogPeriodSelect(busWatchdogPeriodSelect), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
		.regTrap(regTrap), .watchdogFired(watchdogFired));
	sip_ctrl_model ctl (.scl(scl), .sdaPull(sdaPull), .sda(sda));
	function automatic logic [7:0] initVal(input logic [7:0] a);
		return a ^ 8'h5A;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ackIs(input logic a);
		chk({7'h00, ack}, {7'h00, a});
	endtask
	task automatic probe(input logic [6:0] a, input logic expAck);
		ctl.start();
		ctl.putByte({a, 1'b0}, ack);
		ackIs(expAck);
		ctl.stop();
	endtask
	task automatic wrFrame(input logic [7:0] ra, input logic [7:0] d0, input int n);
		ctl.start();
		ctl.putByte({dev, 1'b0}, ack);
		ackIs(1'b0);
		ctl.putByte(ra, ack);
		ackIs(1'b0);
		for (int i = 0; i < n; i++) begin
			ctl.putByte(d0 + 8'(i), ack);
			ackIs(1'b0);
		end
		ctl.stop();
		#2000;
	endtask
	task automatic rdFrame(input logic setPtr, input logic [7:0] ra, input int n);
		ctl.start();
		if (setPtr) begin
			ctl.putByte({dev, 1'b0}, ack);
			ackIs(1'b0);
			ctl.putByte(ra, ack);
			ackIs(1'b0);
			ctl.start();
		end
		ctl.putByte({dev, 1'b1}, ack);
		ackIs(1'b0);
		for (int i = 0; i < n; i++) begin
			ctl.getByte(i == n - 1, rd);
			chk(rd, initVal(ra + 8'(i)));
		end
		chk({7'h00, sdaOe}, 8'h00);
		chk({7'h00, sdaOut}, 8'h00);
		ctl.stop();
	endtask
	task automatic t_basic();
		chk(regAddr, sip_pkg::PTR_RESET);
		rdFrame(1'b0, 8'h00, 2);
		$display("test basic done");
	endtask
	task automatic t_write();
		wrFrame(8'h41, 8'h80, 2);
		chk(regs[8'h41], 8'h80);
		chk(regs[8'h42], 8'h81);
		wrFrame(8'hF0, 8'h10, 3);
		chk(regs[8'hF0], 8'h12);
		chk(regs[8'hF1], initVal(8'hF1));
		// Low power idle after the last write, longer than the performance figure
		#448000;
		$display("test write done");
	endtask
	task automatic t_read();
		rdFrame(1'b1, 8'h12, 6);
		rdFrame(1'b0, 8'h12, 2);
		$display("test read done");
	endtask
	task automatic t_addr();
		probe(7'h2A, 1'b1);
		@(posedge clk) addressSelectPin <= 1'b1;
		repeat (8) @(posedge clk);
		probe(sip_pkg::TARGET_ADDR_LOW, 1'b1);
		dev = sip_pkg::TARGET_ADDR_HIGH;
		rdFrame(1'b1, 8'h30, 1);
		@(posedge clk) addressSelectPin <= 1'b0;
		repeat (8) @(posedge clk);
		dev = sip_pkg::TARGET_ADDR_LOW;
		// The stop after a bare start is ignored, so the address still counts
		ctl.bareStartStop();
		ctl.putByte({dev, 1'b0}, ack);
		ackIs(1'b0);
		ctl.stop();
		$display("test address done");
	endtask
	// Controller freezes the clock low while the device holds its acknowledge
	task automatic dogRun(input logic en, input logic sel, input int lim);
		int n;
		@(posedge clk);
		busWatchdogEnable <= en;
		busWatchdogPeriodSelect <= sel;
		ctl.start();
		for (int i = 6; i >= 0; i--) ctl.clockBit(dev[i], ack);
		ctl.clockBit(1'b0, ack);
		n = 0;
		while (watchdogFired !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, n > lim && n < lim + 12}, 8'h01);
		@(posedge clk);
		chk({7'h00, sdaOe}, {7'h00, !en});
		ctl.clockBit(1'b1, ack);
		ctl.stop();
	endtask
	task automatic t_dog();
		dogRun(1'b1, 1'b0, 50);
		dogRun(1'b1, 1'b1, 200);
		dogRun(1'b0, 1'b0, 390);
		probe(dev, 1'b0);
		$display("test watchdog done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) regs[i] = initVal(8'(i));
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_basic();
		t_write();
		t_read();
		t_addr();
		t_dog();
		conclude();
	end
	// All scenarios take well under half of this span
	initial begin
		#2000000;
		n_fail++;
		conclude();
	end
endmodule
